//--- core/ufl_consts.svh
// Purpose: offsets, field positions, reset values and timing counts of the uart channel control block
// Assumes: register index times four gives the AXI4-Lite byte address
// Notes: included by its bare name
`ifndef UFL_CONSTS_SVH
`define UFL_CONSTS_SVH

`define UFL_IDX_DATA      8'h00
`define UFL_IDX_IRQ_EN    8'h01
`define UFL_IDX_ISR_FCR   8'h02
`define UFL_IDX_LINE_CTRL 8'h03
`define UFL_IDX_LINE_STAT 8'h05
`define UFL_IDX_MODEM_ST  8'h06
`define UFL_IDX_LEVELS    8'h08

`define UFL_FCR_EN        0
`define UFL_FCR_RXRST     1
`define UFL_FCR_TXRST     2
`define UFL_LCR_STB       2
`define UFL_LCR_PEN       3
`define UFL_LCR_BRK       6

`define UFL_IRQ_EN_RST    8'h00
`define UFL_LCR_RST       7'h00

`define UFL_ID_NONE       6'h01
`define UFL_ID_LINE       6'h06
`define UFL_ID_RXDATA     6'h04
`define UFL_ID_TIMEOUT    6'h0C
`define UFL_ID_TXEMPTY    6'h02
`define UFL_ID_MODEM      6'h00
`define UFL_ID_XOFF       6'h10
`define UFL_ID_FLOW       6'h20

`define UFL_RESP_OKAY     2'h0
`define UFL_RESP_SLVERR   2'h2

`define UFL_TICKS_BIT     6'h10
`define UFL_TICKS_STOP15  6'h18
`define UFL_TICKS_STOP2   6'h20
`define UFL_CTO_CHARS     3'h4

`endif

//--- core/ufl_pkg.sv
// Purpose: types shared by the uart channel control block
// Assumes: 32-bit AXI4-Lite data
// Notes: carriers group the bus channels
package ufl_pkg;

    typedef enum logic [2:0] {
        UFL_TX_IDLE  = 3'b000,
        UFL_TX_START = 3'b001,
        UFL_TX_DATA  = 3'b010,
        UFL_TX_PAR   = 3'b011,
        UFL_TX_STOP  = 3'b100
    } ufl_tx_state_t;

    typedef struct packed {
        logic        awvalid;
        logic [31:0] awaddr;
        logic        wvalid;
        logic [31:0] wdata;
        logic [3:0]  wstrb;
        logic        bready;
        logic        arvalid;
        logic [31:0] araddr;
        logic        rready;
    } ufl_axi_req_t;

    typedef struct packed {
        logic        awready;
        logic        wready;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        arready;
        logic        rvalid;
        logic [1:0]  rresp;
        logic [31:0] rdata;
    } ufl_axi_rsp_t;

    typedef struct packed {
        logic       valid;
        logic [7:0] data;
        logic       par_bit;
        logic       framing_err;
        logic       break_flag;
        logic       addr_byte;
    } ufl_rx_char_t;

endpackage : ufl_pkg

//--- core/ufl_uart_ctrl.sv
// Purpose: one uart channel: prioritized interrupt status, fifo control and line format control
// Assumes: inputs synchronous to core_clk_in; baud16 tick is a one-cycle enable at sixteen per bit
// Notes: received characters arrive already deserialised; the block checks their parity
`timescale 1ns/1ns
`default_nettype none
`include "ufl_consts.svh"

// Contract
// - fifo mode: status bit7 is one while tx fifo not full; else mirrors enable
// - with tx level count zero, bit7 one means empty, zero means full
// - fifo mode: status bit6 is one when rx fifo full; else mirrors enable
// - with rx level count zero, bit6 one means full, zero means empty
// - line status interrupt on rx errors or address byte; line status read clears
// - rx data interrupt at trigger level; clears when count drops below trigger
// - timeout after four idle character times with rx data; rx read clears
// - tx empty interrupt on empty or falling below trigger; status read or data write clears
// - modem interrupt on modem input changes; modem status read clears
// - xoff or special character detection interrupt; status read clears
// - flow pin rising during auto flow control interrupts; status read clears
// - fifo control bits 7:3 are ignored on write
// - fifo control bit2 resets tx pointers and count, then self clears
// - fifo control bit1 resets rx pointers and count, then self clears
// - fifo control bit0 selects deep fifos or single byte; reset selects single
// - line control bit7 always reads zero
// - line control bit6 holds serial output low for break
// - parity field: none, odd, even, forced one, forced zero
// - parity enabled: transmitter appends parity, receiver checks it
// - stop field zero gives one stop bit for all word lengths
// - word length five to eight; stop field one gives 1.5 or two stop bits
// - status identifies the pending source by priority
module ufl_uart_ctrl #(
    parameter int DEPTH   = 256,
    parameter int TX_TRIG = 8,
    parameter int RX_TRIG = 8
) (
    input  wire logic                  core_clk_in,
    input  wire logic                  resetn_in,
    input  wire ufl_pkg::ufl_axi_req_t axi_req_in,
    output var  ufl_pkg::ufl_axi_rsp_t axi_rsp_out,
    input  wire logic                  baud16_tick_in,
    input  wire logic                  char_time_tick_in,
    input  wire ufl_pkg::ufl_rx_char_t rx_char_in,
    input  wire logic                  xoff_detect_in,
    input  wire logic                  auto_flow_in,
    input  wire logic                  request_to_send_n_in,
    input  wire logic                  clear_to_send_n_in,
    input  wire logic                  set_ready_n_in,
    input  wire logic                  carrier_detect_n_in,
    input  wire logic                  ring_indicator_n_in,
    output logic                       txd_out,
    output logic                       irq_out
);
    import ufl_pkg::*;

    localparam int AW = $clog2(DEPTH);
    localparam int CW = AW + 1;
    localparam logic [CW-1:0] DEPTH_C   = CW'(DEPTH);
    localparam logic [CW-1:0] TX_TRIG_C = CW'(TX_TRIG);
    localparam logic [CW-1:0] RX_TRIG_C = CW'(RX_TRIG);
    localparam logic [CW-1:0] ONE_C     = CW'(1);

    typedef struct packed {
        ufl_axi_rsp_t  rsp;
        logic          fifo_en;
        logic [6:0]    line_control;
        logic [7:0]    irq_en;
        logic [AW-1:0] tx_wp;
        logic [AW-1:0] tx_rp;
        logic [CW-1:0] tx_cnt;
        logic [AW-1:0] rx_wp;
        logic [AW-1:0] rx_rp;
        logic [CW-1:0] rx_cnt;
        logic          f_line;
        logic          f_cto;
        logic          f_thre;
        logic          f_xoff;
        logic          f_rts;
        logic          f_cts;
        logic          tx_above;
        logic          overrun;
        logic          rx_err_seen;
        logic [3:0]    modem_prev;
        logic [3:0]    modem_delta;
        logic          rts_prev;
        logic          cts_prev;
        logic [2:0]    cto_cnt;
        ufl_tx_state_t tx_st;
        logic [7:0]    tx_sh;
        logic [2:0]    tx_bit;
        logic [5:0]    tx_tick;
        logic          tx_par;
        logic          txd;
        logic          irq;
    } ufl_state_t;

    ufl_state_t s_ff;
    ufl_state_t nxt_s;

    logic [7:0]  tx_mem [DEPTH];
    logic [10:0] rx_mem [DEPTH];

    // parity for the current format: odd, even, forced one, forced zero
    function automatic logic par_calc(input logic [7:0] d, input logic [6:0] l);
        logic [7:0] m;
        logic       x;
        m = d & (8'h1F | (8'hE0 >> (2'h3 - l[1:0])) & 8'hE0);
        x = ^m;
        case (l[5:4])
            2'b00:   par_calc = ~x;
            2'b01:   par_calc = x;
            2'b10:   par_calc = 1'b1;
            default: par_calc = 1'b0;
        endcase
    endfunction : par_calc

    logic          wr_go;
    logic          rd_go;
    logic [7:0]    wr_idx;
    logic [7:0]    rd_idx;
    logic          wr_b0;
    logic [CW-1:0] fifo_lim;
    logic          tx_full;
    logic          rx_full;
    logic          tx_push;
    logic          tx_pop;
    logic          rx_push;
    logic          rx_pop;
    logic          tx_rst;
    logic          rx_rst;
    logic [7:0]    isr_byte;
    logic [7:0]    rd_val;
    logic          rd_ok;
    logic          wr_ok;
    logic [7:0]    rx_masked;
    logic          rx_pe;
    logic          rx_bad;
    logic [3:0]    modem_now;
    logic          tick_end;
    logic [5:0]    stop_ticks;
    logic [6:0]    pend;
    logic [7:0]    rx_head_sh;

    always_comb begin
        wr_go     = s_ff.rsp.awready;
        rd_go     = s_ff.rsp.arready;
        wr_idx    = axi_req_in.awaddr[9:2];
        rd_idx    = axi_req_in.araddr[9:2];
        wr_b0     = wr_go && axi_req_in.wstrb[0];
        fifo_lim  = s_ff.fifo_en ? DEPTH_C : ONE_C;
        tx_full   = s_ff.tx_cnt >= fifo_lim;
        rx_full   = s_ff.rx_cnt >= fifo_lim;
        tx_rst    = wr_b0 && wr_idx == `UFL_IDX_ISR_FCR && axi_req_in.wdata[`UFL_FCR_TXRST];
        rx_rst    = wr_b0 && wr_idx == `UFL_IDX_ISR_FCR && axi_req_in.wdata[`UFL_FCR_RXRST];
        tx_push   = wr_b0 && wr_idx == `UFL_IDX_DATA && !tx_full;
        tx_pop    = s_ff.tx_st == UFL_TX_IDLE && s_ff.tx_cnt != '0;
        rx_pop    = rd_go && rd_idx == `UFL_IDX_DATA && s_ff.rx_cnt != '0;
        rx_push   = rx_char_in.valid && !rx_full;
        rx_masked = rx_char_in.data & (8'h1F | (8'hE0 >> (2'h3 - s_ff.line_control[1:0])) & 8'hE0);
        rx_pe     = s_ff.line_control[`UFL_LCR_PEN] && (rx_char_in.par_bit != par_calc(rx_char_in.data, s_ff.line_control));
        rx_bad    = rx_pe || rx_char_in.framing_err || rx_char_in.break_flag;
        modem_now = {carrier_detect_n_in, ring_indicator_n_in, set_ready_n_in, clear_to_send_n_in};
        tick_end  = baud16_tick_in && s_ff.tx_tick == `UFL_TICKS_BIT - 6'h01;
        stop_ticks = !s_ff.line_control[`UFL_LCR_STB] ? `UFL_TICKS_BIT :
                     (s_ff.line_control[1:0] == 2'b00 ? `UFL_TICKS_STOP15 : `UFL_TICKS_STOP2);
        rx_head_sh = {5'h00, rx_mem[s_ff.rx_rp][10:8]};
        // enabled pending sources, index 0 is the highest priority
        pend[0] = s_ff.f_line && s_ff.irq_en[2];
        pend[1] = s_ff.rx_cnt >= (s_ff.fifo_en ? RX_TRIG_C : ONE_C) && s_ff.irq_en[0];
        pend[2] = s_ff.f_cto && s_ff.irq_en[0];
        pend[3] = s_ff.f_thre && s_ff.irq_en[1];
        pend[4] = (|s_ff.modem_delta) && s_ff.irq_en[3];
        pend[5] = s_ff.f_xoff && s_ff.irq_en[5];
        pend[6] = (s_ff.f_rts && s_ff.irq_en[6]) || (s_ff.f_cts && s_ff.irq_en[7]);
        isr_byte[7] = s_ff.fifo_en ? !tx_full : s_ff.fifo_en;
        isr_byte[6] = s_ff.fifo_en ? rx_full : s_ff.fifo_en;
        if (pend[0]) isr_byte[5:0] = `UFL_ID_LINE;
        else if (pend[1]) isr_byte[5:0] = `UFL_ID_RXDATA;
        else if (pend[2]) isr_byte[5:0] = `UFL_ID_TIMEOUT;
        else if (pend[3]) isr_byte[5:0] = `UFL_ID_TXEMPTY;
        else if (pend[4]) isr_byte[5:0] = `UFL_ID_MODEM;
        else if (pend[5]) isr_byte[5:0] = `UFL_ID_XOFF;
        else if (pend[6]) isr_byte[5:0] = `UFL_ID_FLOW;
        else isr_byte[5:0] = `UFL_ID_NONE;
        rd_ok = 1'b1;
        case (rd_idx)
            `UFL_IDX_DATA:      rd_val = rx_mem[s_ff.rx_rp][7:0];
            `UFL_IDX_IRQ_EN:    rd_val = s_ff.irq_en;
            `UFL_IDX_ISR_FCR:   rd_val = isr_byte;
            `UFL_IDX_LINE_CTRL: rd_val = {1'b0, s_ff.line_control};
            `UFL_IDX_LINE_STAT: rd_val = {s_ff.rx_err_seen, s_ff.tx_cnt == '0 && s_ff.tx_st == UFL_TX_IDLE,
                                          s_ff.tx_cnt == '0, rx_head_sh[2:0] & {3{s_ff.rx_cnt != '0}},
                                          s_ff.overrun, s_ff.rx_cnt != '0};
            `UFL_IDX_MODEM_ST:  rd_val = {~modem_now, s_ff.modem_delta};
            `UFL_IDX_LEVELS:    rd_val = 8'h00;
            default: begin
                rd_val = 8'h00;
                rd_ok  = 1'b0;
            end
        endcase
        wr_ok = wr_idx <= `UFL_IDX_LINE_CTRL;
    end

    always_comb begin
        nxt_s = s_ff;
        nxt_s.rsp.awready = 1'b0;
        nxt_s.rsp.wready  = 1'b0;
        nxt_s.rsp.arready = 1'b0;
        // write channel: address and data taken together, response follows
        if (s_ff.rsp.bvalid && axi_req_in.bready) nxt_s.rsp.bvalid = 1'b0;
        if (!s_ff.rsp.awready && !s_ff.rsp.bvalid && axi_req_in.awvalid && axi_req_in.wvalid) begin
            nxt_s.rsp.awready = 1'b1;
            nxt_s.rsp.wready  = 1'b1;
        end
        if (wr_go) begin
            nxt_s.rsp.bvalid = 1'b1;
            nxt_s.rsp.bresp  = wr_ok ? `UFL_RESP_OKAY : `UFL_RESP_SLVERR;
        end
        if (s_ff.rsp.rvalid && axi_req_in.rready) nxt_s.rsp.rvalid = 1'b0;
        if (!s_ff.rsp.arready && !s_ff.rsp.rvalid && axi_req_in.arvalid) nxt_s.rsp.arready = 1'b1;
        if (rd_go) begin
            nxt_s.rsp.rvalid = 1'b1;
            nxt_s.rsp.rresp  = rd_ok ? `UFL_RESP_OKAY : `UFL_RESP_SLVERR;
            nxt_s.rsp.rdata  = (rd_idx == `UFL_IDX_LEVELS) ?
                               {16'h0000, s_ff.rx_cnt[7:0], s_ff.tx_cnt[7:0]} : {24'h00_0000, rd_val};
        end
        // register writes
        if (wr_b0 && wr_idx == `UFL_IDX_IRQ_EN) nxt_s.irq_en = axi_req_in.wdata[7:0];
        if (wr_b0 && wr_idx == `UFL_IDX_ISR_FCR) nxt_s.fifo_en = axi_req_in.wdata[`UFL_FCR_EN];
        if (wr_b0 && wr_idx == `UFL_IDX_LINE_CTRL) nxt_s.line_control = axi_req_in.wdata[6:0];
        // read side effects, then hardware sets so that a set wins over a clear
        if (rd_go && rd_idx == `UFL_IDX_ISR_FCR) begin
            nxt_s.f_thre = 1'b0;
            nxt_s.f_xoff = 1'b0;
            nxt_s.f_rts  = 1'b0;
            nxt_s.f_cts  = 1'b0;
        end
        if (tx_push) nxt_s.f_thre = 1'b0;
        if (rd_go && rd_idx == `UFL_IDX_LINE_STAT) begin
            nxt_s.f_line      = 1'b0;
            nxt_s.overrun     = 1'b0;
            nxt_s.rx_err_seen = 1'b0;
        end
        if (rd_go && rd_idx == `UFL_IDX_MODEM_ST) nxt_s.modem_delta = 4'h0;
        if (rd_go && rd_idx == `UFL_IDX_DATA) begin
            nxt_s.f_cto   = 1'b0;
            nxt_s.cto_cnt = 3'h0;
        end
        // tx fifo
        nxt_s.tx_cnt = s_ff.tx_cnt + CW'(tx_push) - CW'(tx_pop);
        if (tx_push) nxt_s.tx_wp = s_ff.tx_wp + AW'(1);
        if (tx_pop) nxt_s.tx_rp = s_ff.tx_rp + AW'(1);
        if (s_ff.tx_cnt > TX_TRIG_C) nxt_s.tx_above = 1'b1;
        if (tx_pop && s_ff.tx_cnt == ONE_C && !tx_push) nxt_s.f_thre = 1'b1;
        if (s_ff.fifo_en && s_ff.tx_above && nxt_s.tx_cnt < TX_TRIG_C) begin
            nxt_s.f_thre   = 1'b1;
            nxt_s.tx_above = 1'b0;
        end
        if (tx_rst) begin
            nxt_s.tx_wp    = '0;
            nxt_s.tx_rp    = '0;
            nxt_s.tx_cnt   = '0;
            nxt_s.tx_above = 1'b0;
        end
        // rx fifo
        nxt_s.rx_cnt = s_ff.rx_cnt + CW'(rx_push) - CW'(rx_pop);
        if (rx_push) nxt_s.rx_wp = s_ff.rx_wp + AW'(1);
        if (rx_pop) nxt_s.rx_rp = s_ff.rx_rp + AW'(1);
        if (rx_char_in.valid) begin
            nxt_s.cto_cnt = 3'h0;
            if (rx_full) nxt_s.overrun = 1'b1;
            if (rx_bad) nxt_s.rx_err_seen = 1'b1;
            if (rx_full || rx_bad || rx_char_in.addr_byte) nxt_s.f_line = 1'b1;
        end else if (char_time_tick_in && s_ff.rx_cnt != '0 && !rx_pop && !s_ff.f_cto) begin
            nxt_s.cto_cnt = s_ff.cto_cnt + 3'h1;
            if (s_ff.cto_cnt == `UFL_CTO_CHARS - 3'h1) nxt_s.f_cto = 1'b1;
        end
        if (rx_rst) begin
            nxt_s.rx_wp   = '0;
            nxt_s.rx_rp   = '0;
            nxt_s.rx_cnt  = '0;
            nxt_s.cto_cnt = 3'h0;
        end
        // modem and flow events
        nxt_s.modem_prev  = modem_now;
        nxt_s.modem_delta = nxt_s.modem_delta | (modem_now ^ s_ff.modem_prev);
        nxt_s.rts_prev    = request_to_send_n_in;
        nxt_s.cts_prev    = clear_to_send_n_in;
        if (auto_flow_in && request_to_send_n_in && !s_ff.rts_prev) nxt_s.f_rts = 1'b1;
        if (auto_flow_in && clear_to_send_n_in && !s_ff.cts_prev) nxt_s.f_cts = 1'b1;
        if (xoff_detect_in) nxt_s.f_xoff = 1'b1;
        // transmitter
        if (baud16_tick_in) nxt_s.tx_tick = tick_end ? 6'h00 : s_ff.tx_tick + 6'h01;
        case (s_ff.tx_st)
            UFL_TX_IDLE: begin
                nxt_s.tx_tick = 6'h00;
                if (tx_pop) begin
                    nxt_s.tx_sh  = tx_mem[s_ff.tx_rp];
                    nxt_s.tx_par = par_calc(tx_mem[s_ff.tx_rp], s_ff.line_control);
                    nxt_s.tx_st  = UFL_TX_START;
                end
            end
            UFL_TX_START: begin
                nxt_s.tx_bit = 3'h0;
                if (tick_end) nxt_s.tx_st = UFL_TX_DATA;
            end
            UFL_TX_DATA: begin
                if (tick_end) begin
                    nxt_s.tx_sh  = {1'b0, s_ff.tx_sh[7:1]};
                    nxt_s.tx_bit = s_ff.tx_bit + 3'h1;
                    if (s_ff.tx_bit == {1'b0, s_ff.line_control[1:0]} + 3'h4) begin
                        nxt_s.tx_st = s_ff.line_control[`UFL_LCR_PEN] ? UFL_TX_PAR : UFL_TX_STOP;
                    end
                end
            end
            UFL_TX_PAR: begin
                if (tick_end) nxt_s.tx_st = UFL_TX_STOP;
            end
            UFL_TX_STOP: begin
                if (baud16_tick_in) nxt_s.tx_tick = s_ff.tx_tick + 6'h01;
                if (baud16_tick_in && s_ff.tx_tick == stop_ticks - 6'h01) nxt_s.tx_st = UFL_TX_IDLE;
            end
            default: nxt_s.tx_st = UFL_TX_IDLE;
        endcase
        case (s_ff.tx_st)
            UFL_TX_START: nxt_s.txd = 1'b0;
            UFL_TX_DATA:  nxt_s.txd = s_ff.tx_sh[0];
            UFL_TX_PAR:   nxt_s.txd = s_ff.tx_par;
            default:      nxt_s.txd = 1'b1;
        endcase
        if (s_ff.line_control[`UFL_LCR_BRK]) nxt_s.txd = 1'b0;
        nxt_s.irq = |pend;
    end

    always_ff @(posedge core_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            s_ff        <= '0;
            s_ff.line_control    <= `UFL_LCR_RST;
            s_ff.irq_en <= `UFL_IRQ_EN_RST;
            s_ff.tx_st  <= UFL_TX_IDLE;
            s_ff.txd    <= 1'b1;
            s_ff.modem_prev <= 4'hF;
            s_ff.rts_prev   <= 1'b1;
            s_ff.cts_prev   <= 1'b1;
        end else begin
            s_ff <= nxt_s;
        end
    end

    always_ff @(posedge core_clk_in) begin
        if (tx_push) tx_mem[s_ff.tx_wp] <= axi_req_in.wdata[7:0];
        if (rx_push) rx_mem[s_ff.rx_wp] <= {rx_char_in.break_flag, rx_char_in.framing_err, rx_pe, rx_masked};
    end

    assign axi_rsp_out = s_ff.rsp;
    assign txd_out     = s_ff.txd;
    assign irq_out     = s_ff.irq;

    property p_tx_not_full;
        @(posedge core_clk_in) disable iff (!resetn_in)
        s_ff.fifo_en |-> isr_byte[7] == (s_ff.tx_cnt != DEPTH_C);
    endproperty
    a_tx_not_full: assert property (p_tx_not_full) else $error("tx not-full status wrong");
    property p_rx_full;
        @(posedge core_clk_in) disable iff (!resetn_in)
        (s_ff.fifo_en && s_ff.rx_cnt[AW-1:0] == '0) |-> isr_byte[6] == s_ff.rx_cnt[AW];
    endproperty
    a_rx_full: assert property (p_rx_full) else $error("rx full status wrong");
    property p_irq_follows;
        @(posedge core_clk_in) disable iff (!resetn_in)
        (|pend) |=> irq_out;
    endproperty
    a_irq_follows: assert property (p_irq_follows) else $error("interrupt not raised");
    property p_line_first;
        @(posedge core_clk_in) disable iff (!resetn_in)
        pend[0] |-> isr_byte[5:0] == `UFL_ID_LINE;
    endproperty
    a_line_first: assert property (p_line_first) else $error("line status not top priority");
    property p_tx_reset;
        @(posedge core_clk_in) disable iff (!resetn_in)
        tx_rst |=> s_ff.tx_cnt == '0 && s_ff.tx_wp == s_ff.tx_rp;
    endproperty
    a_tx_reset: assert property (p_tx_reset) else $error("tx fifo not reset");
    property p_break_low;
        @(posedge core_clk_in) disable iff (!resetn_in)
        s_ff.line_control[`UFL_LCR_BRK] |=> !txd_out;
    endproperty
    a_break_low: assert property (p_break_low) else $error("break not driven low");
    property p_lcr_bit7;
        @(posedge core_clk_in) disable iff (!resetn_in)
        (rd_go && rd_idx == `UFL_IDX_LINE_CTRL) |=> axi_rsp_out.rvalid && !axi_rsp_out.rdata[7];
    endproperty
    a_lcr_bit7: assert property (p_lcr_bit7) else $error("line control bit7 not zero");
    property p_line_err;
        @(posedge core_clk_in) disable iff (!resetn_in)
        (rx_char_in.valid && rx_bad) |=> s_ff.f_line ##1 1'b1;
    endproperty
    a_line_err: assert property (p_line_err) else $error("line error not flagged");

endmodule : ufl_uart_ctrl
`default_nettype wire

//--- tb/ufl_far_end.sv
// Purpose: far serial device: delivers received characters and the clear-to-send line level
// Assumes: characters arrive already framed, one per call
// Notes: data lines show inverted data once valid drops
`timescale 1ns/1ns
`default_nettype none
module ufl_far_end (
    input  wire logic          clk_in,
    output ufl_pkg::ufl_rx_char_t rx_char_out,
    output logic               cts_n_out
);
    import ufl_pkg::*;
    initial begin
        rx_char_out = '0;
        cts_n_out   = 1'b1;
    end
    task automatic send(input logic [7:0] d, input logic fe);
        @(posedge clk_in) rx_char_out <= '{1'b1, d, 1'b0, fe, 1'b0, 1'b0};
        @(posedge clk_in) rx_char_out <= '{1'b0, ~d, 1'b1, ~fe, 1'b1, 1'b1};
    endtask : send
    task automatic cts(input logic v);
        @(posedge clk_in) cts_n_out <= v;
    endtask : cts
endmodule : ufl_far_end
`default_nettype wire

//--- tb/ufl_uart_ctrl_bench.sv
// Purpose: register level tests of the uart channel control block
// Assumes: baud tick always on; modem inputs other than clear-to-send stay idle
// Notes: status codes are checked with only the source under test enabled, except the line status and timeout checks, which also enable rx data
`timescale 1ns/1ns
`default_nettype none
module ufl_uart_ctrl_bench;
    import ufl_pkg::*;
    logic clk = 0, rstn = 0, txd, irq, cts_n;
    logic ct = 0, xd = 0, af = 0, rts_n = 1;
    ufl_axi_req_t rq = '0;
    ufl_axi_rsp_t rs;
    ufl_rx_char_t rxc;
    logic [31:0] rv;
    logic [1:0] rsp;
    int num_errors = 0, n_compared = 0;
    ufl_uart_ctrl DUT (.core_clk_in(clk), .resetn_in(rstn), .axi_req_in(rq), .axi_rsp_out(rs),
        .baud16_tick_in(1'b1), .char_time_tick_in(ct), .rx_char_in(rxc), .xoff_detect_in(xd),
        .auto_flow_in(af), .request_to_send_n_in(rts_n), .clear_to_send_n_in(cts_n),
        .set_ready_n_in(1'b1), .carrier_detect_n_in(1'b1), .ring_indicator_n_in(1'b1),
        .txd_out(txd), .irq_out(irq));
    ufl_far_end FE (.clk_in(clk), .rx_char_out(rxc), .cts_n_out(cts_n));
    initial forever #20 clk = ~clk;
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            num_errors++;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic wr(input logic [7:0] i, input logic [7:0] d);
        rq.awaddr <= {22'h0, i, 2'b00};
        rq.wdata  <= {24'h0, d};
        rq.wstrb  <= 4'h1;
        rq.awvalid <= 1; rq.wvalid <= 1; rq.bready <= 1;
        do @(posedge clk); while (!(rs.awready && rs.wready));
        rq.awvalid <= 0; rq.wvalid <= 0;
        do @(posedge clk); while (!rs.bvalid);
        rsp = rs.bresp;
    endtask : wr
    task automatic rd(input logic [7:0] i);
        rq.araddr <= {22'h0, i, 2'b00};
        rq.arvalid <= 1; rq.rready <= 1;
        do @(posedge clk); while (!rs.arready);
        rq.arvalid <= 0;
        do @(posedge clk); while (!rs.rvalid);
        rv = rs.rdata; rsp = rs.rresp;
    endtask : rd
    task automatic tally_and_finish;
        $display("compared %0d, errors %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : tally_and_finish
    initial begin
        repeat (20000) @(posedge clk);
        num_errors++;
        tally_and_finish();
    end
    initial begin
        repeat (8) @(posedge clk);
        rstn <= 1;
        @(posedge clk);
        rd(3); chk(rv, 0);
        rd(2); chk(rv, 32'h01); chk(irq, 0);
        wr(3, 8'hff); rd(3); chk(rv, 32'h7f);
        wr(3, 8'h43); repeat (3) @(posedge clk); chk(txd, 0);
        wr(3, 8'h03); repeat (3) @(posedge clk); chk(txd, 1);
        wr(2, 8'hf9); rd(2); chk(rv[7:6], 2'b10);
        FE.send(8'h55, 0); FE.send(8'h66, 0);
        rd(8); chk(rv[15:8], 8'h02);
        wr(2, 8'h03); rd(8); chk(rv[15:8], 8'h00);
        repeat (3) wr(0, 8'haa);
        wr(2, 8'h05); rd(8); chk(rv[7:0], 8'h00);
        wr(2, 8'h00); rd(2); chk(rv[7:6], 2'b00);
        repeat (400) @(posedge clk);
        rd(2); wr(1, 8'h01); FE.send(8'h12, 0); repeat (2) @(posedge clk);
        rd(2); chk(rv, 32'h04); chk(irq, 1);
        rd(0); chk(rv, 32'h12); rd(2); chk(rv, 32'h01);
        wr(1, 8'h05); FE.send(8'h34, 1); repeat (2) @(posedge clk);
        rd(2); chk(rv, 32'h06);
        rd(5); chk(rv, 32'he9); rd(2); chk(rv, 32'h04); rd(0); chk(rv, 32'h34);
        wr(1, 8'h02); wr(0, 8'h5a); repeat (3) @(posedge clk);
        chk(irq, 1); rd(2); chk(rv, 32'h02); rd(2); chk(rv, 32'h01);
        repeat (400) @(posedge clk);
        wr(1, 8'h08); FE.cts(0); repeat (3) @(posedge clk);
        rd(2); chk(rv, 32'h00); rd(6); chk(rv, 32'h11); rd(2); chk(rv, 32'h01);
        wr(2, 8'h01); wr(1, 8'h01); FE.send(8'h21, 0);
        repeat (4) begin
            ct <= 1;
            @(posedge clk);
            ct <= 0;
            @(posedge clk);
        end
        rd(2); chk(rv, 32'h8c);
        rd(0); chk(rv, 32'h21); rd(2); chk(rv, 32'h81);
        wr(1, 8'h20); xd <= 1; @(posedge clk); xd <= 0;
        rd(2); chk(rv, 32'h90); rd(2); chk(rv, 32'h81);
        wr(1, 8'h40); af <= 1; rts_n <= 0; @(posedge clk); rts_n <= 1;
        rd(2); chk(rv, 32'ha0); rd(2); chk(rv, 32'h81);
        wr(5, 8'h00); chk(rsp, 2'h2);
        rd(7); chk(rsp, 2'h2);
        tally_and_finish();
    end
endmodule : ufl_uart_ctrl_bench
`default_nettype wire
